// [rtl/cap_pkg.sv]
// Constants and types for the identify capability field block
package cap_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the bus
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  CAPS_OFFSET   = 8'h00;
    localparam logic [7:0]  CTRL_OFFSET   = 8'h04;
    localparam logic [7:0]  STATUS_OFFSET = 8'h08;
    localparam logic [7:0]  STATS_OFFSET  = 8'h0c;
    localparam logic [7:0]  REASON_OFFSET = 8'h10;

    // Control fields and their values after reset
    localparam int unsigned CTRL_ADMIT  = 0;
    localparam int unsigned CTRL_CLEAR  = 1;
    localparam logic        ADMIT_RESET = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // Positions in the support bitmap
    localparam int unsigned CAP_SEC    = 0;
    localparam int unsigned CAP_FMT    = 1;
    localparam int unsigned CAP_FW     = 2;
    localparam int unsigned CAP_NS     = 3;
    localparam int unsigned CAP_TEST   = 4;
    localparam int unsigned CAP_DIR    = 5;
    localparam int unsigned CAP_MGMT   = 6;
    localparam int unsigned CAP_VIRT   = 7;
    localparam int unsigned CAP_BELL   = 8;
    localparam int unsigned CAP_LBA    = 9;
    localparam int unsigned CAP_RSV_LO = 10;
    localparam int unsigned CAP_RSV_HI = 15;
    localparam int unsigned MAP_W      = 16;

    // Word holding structure bytes 256 to 259, lowest byte first
    localparam int unsigned ABORT_LIM_LSB = 16;
    localparam int unsigned AER_LIM_LSB   = 24;
    localparam int unsigned LIM_W         = 8;

    // Status and statistics layout
    localparam int unsigned CNT_W          = 9;
    localparam int unsigned ABORT_USED_LSB = 0;
    localparam int unsigned AER_USED_LSB   = 16;
    localparam int unsigned STAT_W         = 16;
    localparam int unsigned REJ_KIND_LSB   = 8;

    // Recommended number of slots for both limited command classes
    localparam int unsigned SLOTS_REC = 4;

    ////////////////////////////////////////////////////////////////////
    typedef enum logic [4:0] {
        K_OTHER   = 5'h00,
        K_SEC_TX  = 5'h01,
        K_SEC_RX  = 5'h02,
        K_FORMAT  = 5'h03,
        K_FW_CMT  = 5'h04,
        K_FW_LOAD = 5'h05,
        K_NS_MGMT = 5'h06,
        K_TEST    = 5'h07,
        K_DIR_TX  = 5'h08,
        K_DIR_RX  = 5'h09,
        K_MGMT_TX = 5'h0a,
        K_MGMT_RX = 5'h0b,
        K_VIRT    = 5'h0c,
        K_BELL    = 5'h0d,
        K_LBA     = 5'h0e,
        K_ABORT   = 5'h0f,
        K_AER     = 5'h10
    } cmd_kind_t;

    localparam int unsigned KINDS = 17;

    typedef enum logic [1:0] {
        R_NONE  = 2'h0,
        R_UNSUP = 2'h1,
        R_LIMIT = 2'h2,
        R_OFF   = 2'h3
    } reason_t;

    typedef struct packed {
        logic      valid;
        cmd_kind_t kind;
    } cmd_req_t;

    typedef struct packed {
        logic    accept;
        logic    reject;
        reason_t reason;
    } cmd_ans_t;

endpackage

// [rtl/id_caps.sv]
// Identify capability fields with command admission and register access
module id_caps #(
    parameter bit          HAS_SEC     = 1'b1,
    parameter bit          HAS_FMT     = 1'b1,
    parameter bit          HAS_FW      = 1'b1,
    parameter bit          HAS_NS      = 1'b0,
    parameter bit          HAS_TEST    = 1'b0,
    parameter bit          HAS_DIR     = 1'b0,
    parameter bit          HAS_MGMT    = 1'b0,
    parameter bit          HAS_VIRT    = 1'b0,
    parameter bit          HAS_BELL    = 1'b0,
    parameter bit          HAS_LBA     = 1'b0,
    parameter int unsigned ABORT_SLOTS = cap_pkg::SLOTS_REC,
    parameter int unsigned AER_SLOTS   = cap_pkg::SLOTS_REC
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [cap_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire cap_pkg::cmd_req_t          cmd_req,
    input  wire logic                       abort_done,
    input  wire logic                       aer_done,
    output cap_pkg::cmd_ans_t               cmd_ans,
    output logic      [31:0]                caps_word
);

    ////////////////////////////////////////////////////////////////////
    // Fixed capability image
    localparam logic [cap_pkg::MAP_W-1:0] CAP_MAP = {
        6'h00,
        HAS_LBA,
        HAS_BELL,
        HAS_VIRT,
        HAS_MGMT,
        HAS_DIR,
        HAS_TEST,
        HAS_NS,
        HAS_FW,
        HAS_FMT,
        HAS_SEC
    };

    // Zero based limits, so slots must lie in 1..256
    localparam logic [7:0] ABORT_LIM = 8'(ABORT_SLOTS - 1);
    localparam logic [7:0] AER_LIM   = 8'(AER_SLOTS - 1);

    localparam logic [31:0] CAPS = {AER_LIM, ABORT_LIM, CAP_MAP};

    ////////////////////////////////////////////////////////////////////
    // Admission decode from the same bitmap that is reported
    function automatic logic kind_ok(input cap_pkg::cmd_kind_t k);
        logic ok;
        ok = 1'b0;
        case (k)
            cap_pkg::K_SEC_TX,
            cap_pkg::K_SEC_RX:  ok = CAP_MAP[cap_pkg::CAP_SEC];
            cap_pkg::K_FORMAT:  ok = CAP_MAP[cap_pkg::CAP_FMT];
            cap_pkg::K_FW_CMT,
            cap_pkg::K_FW_LOAD: ok = CAP_MAP[cap_pkg::CAP_FW];
            cap_pkg::K_NS_MGMT: ok = CAP_MAP[cap_pkg::CAP_NS];
            cap_pkg::K_TEST:    ok = CAP_MAP[cap_pkg::CAP_TEST];
            cap_pkg::K_DIR_TX,
            cap_pkg::K_DIR_RX:  ok = CAP_MAP[cap_pkg::CAP_DIR];
            cap_pkg::K_MGMT_TX,
            cap_pkg::K_MGMT_RX: ok = CAP_MAP[cap_pkg::CAP_MGMT];
            cap_pkg::K_VIRT:    ok = CAP_MAP[cap_pkg::CAP_VIRT];
            cap_pkg::K_BELL:    ok = CAP_MAP[cap_pkg::CAP_BELL];
            cap_pkg::K_LBA:     ok = CAP_MAP[cap_pkg::CAP_LBA];
            cap_pkg::K_OTHER,
            cap_pkg::K_ABORT,
            cap_pkg::K_AER:     ok = 1'b1;
            // Codes outside the kind list are refused as unsupported
            default:            ok = 1'b0;
        endcase
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Signals
    logic                      admit_enable;
    logic                      clear_stats;
    logic [cap_pkg::CNT_W-1:0] abort_used;
    logic [cap_pkg::CNT_W-1:0] aer_used;
    logic                      abort_full;
    logic                      aer_full;
    logic [cap_pkg::STAT_W-1:0] accept_count;
    logic [cap_pkg::STAT_W-1:0] reject_count;
    cap_pkg::reason_t          rej_reason;
    cap_pkg::cmd_kind_t        rej_kind;
    cap_pkg::cmd_kind_t        ans_kind;
    logic                      supported;
    logic                      limit_hit;
    logic                      admit;
    logic                      refuse;
    cap_pkg::reason_t          next_reason;
    logic                      abort_take;
    logic                      aer_take;
    logic                      access;
    logic                      bus_write;
    logic                      ctrl_write;
    logic [31:0]               next_rdata;
    logic                      next_slverr;

    ////////////////////////////////////////////////////////////////////
    // Admission decision
    always_comb begin
        supported = kind_ok(cmd_req.kind);
        limit_hit = (cmd_req.kind == cap_pkg::K_ABORT && abort_full)
                 || (cmd_req.kind == cap_pkg::K_AER && aer_full);
        admit     = cmd_req.valid && admit_enable && supported && !limit_hit;
        refuse    = cmd_req.valid && !admit;
        // Disabled outranks unsupported, which outranks a full class
        if (!admit_enable) begin
            next_reason = cap_pkg::R_OFF;
        end else if (!supported) begin
            next_reason = cap_pkg::R_UNSUP;
        end else if (limit_hit) begin
            next_reason = cap_pkg::R_LIMIT;
        end else begin
            next_reason = cap_pkg::R_NONE;
        end
    end

    assign abort_take = admit && (cmd_req.kind == cap_pkg::K_ABORT);
    assign aer_take   = admit && (cmd_req.kind == cap_pkg::K_AER);

    // Abort commands hold a slot until they finish executing
    slot_counter #(
        .SLOTS (ABORT_SLOTS),
        .CW    (cap_pkg::CNT_W)
    ) abort_slots (
        .pclk    (pclk),
        .presetn (presetn),
        .take    (abort_take),
        .give    (abort_done),
        .used    (abort_used),
        .full    (abort_full)
    );

    // Event requests stay outstanding until an event completes one
    slot_counter #(
        .SLOTS (AER_SLOTS),
        .CW    (cap_pkg::CNT_W)
    ) aer_slots (
        .pclk    (pclk),
        .presetn (presetn),
        .take    (aer_take),
        .give    (aer_done),
        .used    (aer_used),
        .full    (aer_full)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ans  <= '0;
            ans_kind <= cap_pkg::K_OTHER;
        end else begin
            cmd_ans.accept <= admit;
            cmd_ans.reject <= refuse;
            cmd_ans.reason <= refuse ? next_reason : cap_pkg::R_NONE;
            if (cmd_req.valid) begin
                ans_kind <= cmd_req.kind;
            end
        end
    end

    // Image is loaded on the first edge so reset shows an empty word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            caps_word <= '0;
        end else begin
            caps_word <= CAPS;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state, write lands on the pready edge
    assign access     = psel && penable;
    assign bus_write  = access && pready && pwrite;
    assign ctrl_write = bus_write && (paddr == cap_pkg::CTRL_OFFSET)
                     && pstrb[0];

    always_comb begin
        next_rdata  = '0;
        next_slverr = 1'b0;
        case (paddr)
            cap_pkg::CAPS_OFFSET: begin
                next_rdata = CAPS;
            end
            cap_pkg::CTRL_OFFSET: begin
                next_rdata[cap_pkg::CTRL_ADMIT] = admit_enable;
            end
            cap_pkg::STATUS_OFFSET: begin
                next_rdata[cap_pkg::ABORT_USED_LSB +: cap_pkg::CNT_W]
                    = abort_used;
                next_rdata[cap_pkg::AER_USED_LSB +: cap_pkg::CNT_W]
                    = aer_used;
            end
            cap_pkg::STATS_OFFSET: begin
                next_rdata = {reject_count, accept_count};
            end
            cap_pkg::REASON_OFFSET: begin
                next_rdata[1:0] = rej_reason;
                next_rdata[cap_pkg::REJ_KIND_LSB +: 5] = rej_kind;
            end
            default: begin
                next_slverr = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= access && !pready;
            pslverr <= access && !pready && next_slverr;
            if (access && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control register; the clear bit is a pulse and reads back zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            admit_enable <= cap_pkg::ADMIT_RESET;
            clear_stats  <= 1'b0;
        end else begin
            clear_stats <= ctrl_write && pwdata[cap_pkg::CTRL_CLEAR];
            if (ctrl_write) begin
                admit_enable <= pwdata[cap_pkg::CTRL_ADMIT];
            end
        end
    end

    // Counters saturate; an answer in the clear cycle still counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accept_count <= '0;
        end else if (clear_stats) begin
            accept_count <= {{(cap_pkg::STAT_W-1){1'b0}}, cmd_ans.accept};
        end else if (cmd_ans.accept && accept_count != '1) begin
            accept_count <= accept_count + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reject_count <= '0;
        end else if (clear_stats) begin
            reject_count <= {{(cap_pkg::STAT_W-1){1'b0}}, cmd_ans.reject};
        end else if (cmd_ans.reject && reject_count != '1) begin
            reject_count <= reject_count + 1'b1;
        end
    end

    // Last refusal is kept for software until the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rej_reason <= cap_pkg::R_NONE;
            rej_kind   <= cap_pkg::K_OTHER;
        end else if (refuse) begin
            rej_reason <= next_reason;
            rej_kind   <= cmd_req.kind;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    logic [cap_pkg::KINDS-1:0] acc_hot;

    assign acc_hot = cmd_ans.accept
                   ? cap_pkg::KINDS'(1) << ans_kind : '0;

    default clocking chk_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_caps_read: assert property (
        access && !pready && !pwrite && paddr == cap_pkg::CAPS_OFFSET
        |=> pready && !pslverr && prdata == CAPS)
        else $error("capability word read back wrong");

    a_rsv_zero: assert property (
        ##1 caps_word[cap_pkg::CAP_RSV_HI:cap_pkg::CAP_RSV_LO] == '0)
        else $error("reserved bitmap bits not zero");

    a_lba_gate: assert property (
        acc_hot[cap_pkg::K_LBA] |-> caps_word[cap_pkg::CAP_LBA])
        else $error("block status accepted while not reported");

    a_bell_gate: assert property (
        acc_hot[cap_pkg::K_BELL] |-> caps_word[cap_pkg::CAP_BELL])
        else $error("doorbell config accepted while not reported");

    a_virt_gate: assert property (
        acc_hot[cap_pkg::K_VIRT] |-> caps_word[cap_pkg::CAP_VIRT])
        else $error("virtualization accepted while not reported");

    a_mgmt_gate: assert property (
        acc_hot[cap_pkg::K_MGMT_TX] || acc_hot[cap_pkg::K_MGMT_RX]
        |-> caps_word[cap_pkg::CAP_MGMT])
        else $error("management pair accepted while not reported");

    a_dir_pair: assert property (
        cmd_req.valid && admit_enable && CAP_MAP[cap_pkg::CAP_DIR]
        && (cmd_req.kind == cap_pkg::K_DIR_TX
            || cmd_req.kind == cap_pkg::K_DIR_RX)
        |=> cmd_ans.accept && caps_word[cap_pkg::CAP_DIR])
        else $error("directive command refused while reported");

    a_test_gate: assert property (
        acc_hot[cap_pkg::K_TEST] |-> caps_word[cap_pkg::CAP_TEST])
        else $error("self-test accepted while not reported");

    a_ns_gate: assert property (
        acc_hot[cap_pkg::K_NS_MGMT] |-> caps_word[cap_pkg::CAP_NS])
        else $error("namespace management accepted while not reported");

    a_fw_gate: assert property (
        acc_hot[cap_pkg::K_FW_CMT] || acc_hot[cap_pkg::K_FW_LOAD]
        |-> caps_word[cap_pkg::CAP_FW])
        else $error("firmware command accepted while not reported");

    a_fmt_gate: assert property (
        acc_hot[cap_pkg::K_FORMAT] |-> caps_word[cap_pkg::CAP_FMT])
        else $error("format accepted while not reported");

    a_sec_gate: assert property (
        acc_hot[cap_pkg::K_SEC_TX] || acc_hot[cap_pkg::K_SEC_RX]
        |-> caps_word[cap_pkg::CAP_SEC])
        else $error("security pair accepted while not reported");

    a_abort_limit: assert property (
        cmd_req.valid && cmd_req.kind == cap_pkg::K_ABORT
        && abort_used == cap_pkg::CNT_W'(ABORT_SLOTS)
        |=> cmd_ans.reject && cmd_ans.reason != cap_pkg::R_NONE
        && caps_word[cap_pkg::ABORT_LIM_LSB +: cap_pkg::LIM_W]
           == ABORT_LIM)
        else $error("abort taken beyond the reported limit");

    a_aer_limit: assert property (
        cmd_req.valid && cmd_req.kind == cap_pkg::K_AER
        && aer_used == cap_pkg::CNT_W'(AER_SLOTS)
        |=> cmd_ans.reject
        && caps_word[cap_pkg::AER_LIM_LSB +: cap_pkg::LIM_W] == AER_LIM)
        else $error("event request taken beyond the reported limit");

    a_admit_match: assert property (
        cmd_req.valid && admit_enable && !limit_hit
        |=> cmd_ans.accept == kind_ok(ans_kind)
        && cmd_ans.reject != cmd_ans.accept)
        else $error("admission disagrees with reported bitmap");

    a_off_refuse: assert property (
        cmd_req.valid && !admit_enable
        |=> cmd_ans.reject && cmd_ans.reason == cap_pkg::R_OFF)
        else $error("command accepted while admission disabled");

endmodule

// [rtl/slot_counter.sv]
// Counter of occupied slots for one class of limited commands
module slot_counter #(
    parameter int unsigned SLOTS = cap_pkg::SLOTS_REC,
    parameter int unsigned CW    = cap_pkg::CNT_W
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          take,
    input  wire logic          give,
    output logic [CW-1:0]      used,
    output logic               full
);
    localparam logic [CW-1:0] LIMIT = CW'(SLOTS);

    logic take_ok;
    logic give_ok;

    // Full comes from the count so the caller refuses a take at once
    assign full    = (used == LIMIT);
    assign take_ok = take && !full;
    // A stray give on an empty count is dropped rather than wrapping
    assign give_ok = give && (used != '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            used <= '0;
        end else if (take_ok && !give_ok) begin
            used <= used + 1'b1;
        end else if (give_ok && !take_ok) begin
            used <= used - 1'b1;
        end
    end

endmodule

// [test/host_model.sv]
// Host-side model issuing admin commands and completing limited ones
module host_model (
    input  wire logic              pclk,
    output cap_pkg::cmd_req_t      cmd_req,
    output logic                   abort_done,
    output logic                   aer_done,
    input  wire cap_pkg::cmd_ans_t cmd_ans
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_req = '0;
        abort_done = 1'b0;
        aer_done = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Gap cycles let the host be slow as well as prompt
    task automatic issue(input logic [4:0] k, input int gap,
                         output cap_pkg::cmd_ans_t a);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        cmd_req <= {1'b1, k};
        @(posedge pclk);
        cmd_req <= '0;
        // Answer stands for one cycle; take it at the edge that ends it
        @(posedge pclk);
        a = cmd_ans;
    endtask

    // One completion pulse; ev selects event request over abort
    task automatic finish(input bit ev);
        @(posedge pclk);
        if (ev) aer_done <= 1'b1;
        else abort_done <= 1'b1;
        @(posedge pclk);
        aer_done <= 1'b0;
        abort_done <= 1'b0;
    endtask
endmodule

// [test/test_identify_admin_capability_fields.sv]
// Self-checking bench for the identify capability fields
module test_identify_admin_capability_fields;
    timeunit 1ns;
    timeprecision 1ps;
    // Bitmap and event slots not the defaults (aborts keep 4), so a hard-wired image would show
    localparam logic [9:0]  HAS    = 10'h2a5;
    localparam int unsigned ABORTS = 4;
    localparam int unsigned AERS   = 5;

    logic                pclk, presetn, psel, penable, pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, caps_word;
    logic [3:0]          pstrb;
    logic                pready, pslverr, abort_done, aer_done, admit;
    cap_pkg::cmd_req_t   cmd_req;
    cap_pkg::cmd_ans_t   cmd_ans;
    int                  num_errors, samples_checked, seed, n_abort, n_aer;
    int                  n_acc, n_rej;

    id_caps #(.HAS_SEC(HAS[0]), .HAS_FMT(HAS[1]), .HAS_FW(HAS[2]),
        .HAS_NS(HAS[3]), .HAS_TEST(HAS[4]), .HAS_DIR(HAS[5]),
        .HAS_MGMT(HAS[6]), .HAS_VIRT(HAS[7]), .HAS_BELL(HAS[8]),
        .HAS_LBA(HAS[9]), .ABORT_SLOTS(ABORTS), .AER_SLOTS(AERS)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_req(cmd_req), .abort_done(abort_done), .aer_done(aer_done),
        .cmd_ans(cmd_ans), .caps_word(caps_word));

    host_model host (.pclk(pclk), .cmd_req(cmd_req), .cmd_ans(cmd_ans),
        .abort_done(abort_done), .aer_done(aer_done));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] image();
        return {8'(AERS - 1), 8'(ABORTS - 1), 6'h00, HAS};
    endfunction

    function automatic logic supported(logic [4:0] k);
        case (k)
            5'h00, 5'h0f, 5'h10: return 1'b1;
            5'h01, 5'h02: return HAS[0];
            5'h03: return HAS[1];
            5'h04, 5'h05: return HAS[2];
            5'h06: return HAS[3];
            5'h07: return HAS[4];
            5'h08, 5'h09: return HAS[5];
            5'h0a, 5'h0b: return HAS[6];
            5'h0c: return HAS[7];
            5'h0d: return HAS[8];
            5'h0e: return HAS[9];
            default: return 1'b0;
        endcase
    endfunction

    function automatic cap_pkg::cmd_ans_t expect_ans(logic [4:0] k);
        cap_pkg::reason_t r;
        r = !admit ? cap_pkg::R_OFF : !supported(k) ? cap_pkg::R_UNSUP :
            (k == 5'h0f && n_abort == ABORTS) ||
            (k == 5'h10 && n_aer == AERS) ? cap_pkg::R_LIMIT :
            cap_pkg::R_NONE;
        return '{r == cap_pkg::R_NONE, r != cap_pkg::R_NONE, r};
    endfunction

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'h1;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            check(32'h0, 32'h1, "pready timeout");
            summarize();
        end
    endtask

    task automatic cmd(input logic [4:0] k);
        cap_pkg::cmd_ans_t a, e;
        e = expect_ans(k);
        host.issue(k, $random(seed) & 1, a);
        check(32'(a), 32'(e), "answer");
        if (e.accept) n_acc++;
        else n_rej++;
        if (e.accept && k == 5'h0f) n_abort++;
        if (e.accept && k == 5'h10) n_aer++;
    endtask

    task automatic free_one(input bit ev);
        host.finish(ev);
        if (ev) n_aer--;
        else n_abort--;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    initial begin
        repeat (100000) @(posedge pclk);
        check(32'h0, 32'h1, "run timeout");
        summarize();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        int          i;
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {num_errors, samples_checked, n_abort, n_aer, n_acc, n_rej} = '0;
        seed = 10204;
        admit = 1'b1;
        repeat (16) @(posedge pclk);
        check(caps_word, 32'h0, "caps in reset");
        check(32'(cmd_ans), 32'h0, "answer in reset");
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check(caps_word, image(), "caps port");
        apb(1'b0, cap_pkg::CAPS_OFFSET, 32'h0, r, e);
        check(r, image(), "caps read");
        check(32'(e), 32'h0, "caps error");
        for (i = 0; i < 32; i++) begin
            cmd(i[4:0]);
            if (n_abort > 0) free_one(1'b0);
            if (n_aer > 0) free_one(1'b1);
        end
        repeat (ABORTS + 1) cmd(5'h0f);
        repeat (AERS + 1) cmd(5'h10);
        while (n_abort > 0) free_one(1'b0);
        while (n_aer > 0) free_one(1'b1);
        repeat (200) begin
            i = $random(seed);
            cmd(i[4:0]);
            if (i[6] && n_abort > 0) free_one(1'b0);
            if (i[7] && n_aer > 0) free_one(1'b1);
        end
        apb(1'b0, cap_pkg::STATUS_OFFSET, 32'h0, r, e);
        check(r, (32'(n_aer) << 16) | 32'(n_abort), "status");
        apb(1'b0, cap_pkg::STATS_OFFSET, 32'h0, r, e);
        check(r, (32'(n_rej) << 16) | 32'(n_acc), "stats");
        // Clear pulse with admission kept on; clear bit reads back zero
        apb(1'b1, cap_pkg::CTRL_OFFSET, 32'h3, r, e);
        apb(1'b0, cap_pkg::CTRL_OFFSET, 32'h0, r, e);
        check(r, 32'h1, "ctrl readback");
        apb(1'b0, cap_pkg::STATS_OFFSET, 32'h0, r, e);
        check(r, 32'h0, "stats cleared");
        // Admission off refuses all but must leave the image alone
        apb(1'b1, cap_pkg::CTRL_OFFSET, 32'h0, r, e);
        admit = 1'b0;
        cmd(5'h01);
        apb(1'b0, cap_pkg::REASON_OFFSET, 32'h0, r, e);
        check(r & 32'h1f03, 32'h0103, "reason");
        check(caps_word, image(), "caps kept");
        apb(1'b1, cap_pkg::CTRL_OFFSET, 32'h1, r, e);
        admit = 1'b1;
        apb(1'b0, 8'h40, 32'h0, r, e);
        check(32'(e), 32'h1, "unmapped");
        // Reset in mid-run empties the word and the counts, then reloads
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check(caps_word, 32'h0, "caps in second reset");
        presetn <= 1'b1;
        n_abort = 0;
        n_aer = 0;
        repeat (2) @(posedge pclk);
        check(caps_word, image(), "caps reloaded");
        apb(1'b0, cap_pkg::STATUS_OFFSET, 32'h0, r, e);
        check(r, 32'h0, "status after reset");
        summarize();
    end
endmodule
